// file: src/ccm_pkg.sv
// Package with register map, field layout, reset values and states of the CCM control slice.
package ccm_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFF_KS_START   = 12'h000;
  localparam logic [11:0] OFF_CI_START   = 12'h004;
  localparam logic [11:0] OFF_KS_DONE    = 12'h100;
  localparam logic [11:0] OFF_CI_DONE    = 12'h104;
  localparam logic [11:0] OFF_ERR_EVENT  = 12'h108;
  localparam logic [11:0] OFF_SHORTCUT   = 12'h200;
  localparam logic [11:0] OFF_IRQ_SET    = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR    = 12'h308;
  localparam logic [11:0] OFF_MIC_RESULT = 12'h400;
  localparam logic [11:0] OFF_UNIT_EN    = 12'h500;
  // Field positions inside the enable registers and the shortcut register.
  localparam int BIT_KS_DONE   = 0;
  localparam int BIT_CI_DONE   = 1;
  localparam int BIT_ERROR     = 2;
  localparam int BIT_SHORTCUT  = 0;
  localparam int NUM_EVENTS    = 3;
  // Unit enable field values and reset values.
  localparam logic [1:0]  UNIT_OFF       = 2'h0;
  localparam logic [1:0]  UNIT_ON        = 2'h2;
  localparam logic [2:0]  RST_IRQ_EN     = 3'h0;
  localparam logic [2:0]  RST_EVENTS     = 3'h0;
  localparam logic [1:0]  RST_UNIT_EN    = 2'h0;
  localparam logic        RST_SHORTCUT   = 1'b0;
  localparam logic        RST_MIC        = 1'b0;
  // Default operation lengths in clock cycles at 100 MHz.
  localparam int KS_CYCLES_DEF = 16;
  localparam int CI_CYCLES_DEF = 32;
  // Engine states, Gray coded along idle, key-stream, cipher.
  typedef enum logic [1:0] {
    CCM_IDLE = 2'b00,
    CCM_KS   = 2'b01,
    CCM_CI   = 2'b11
  } ccm_state_t;
endpackage

// file: src/ccm_ctrl.sv
// CCM control slice: task start, completion events, shortcut, interrupt enables, MIC status and unit enable.
//
// Summary of operation
// - Shortcut chains key-stream done into cipher start.
// - Set register bit 0 enables key-stream interrupt.
// - Set register bit 1 enables cipher-done interrupt.
// - Set register bit 2 enables error interrupt.
// - Clear register bit 0 disables key-stream interrupt.
// - Clear register bit 1 disables cipher-done interrupt.
// - Clear register bit 2 disables error interrupt.
// - Unit enable field: 0 off, 2 on.
// - Key-stream task runs, self-ends, raises done event.
// - Cipher task runs, self-ends, raises done event.
`timescale 1ns/10ps
module ccm_ctrl #(
  parameter int KS_CYCLES = ccm_pkg::KS_CYCLES_DEF,
  parameter int CI_CYCLES = ccm_pkg::CI_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        decrypt_mode,
  input  wire logic        mic_pass,
  output logic             keystream_busy,
  output logic             cipher_busy,
  output logic             irq
);

  localparam int CW = $clog2((KS_CYCLES > CI_CYCLES ? KS_CYCLES : CI_CYCLES) + 1);

  ccm_pkg::ccm_state_t state;
  logic [CW-1:0]       cnt;
  logic [2:0]          events;
  logic [2:0]          irq_en;
  logic                shortcut_en;
  logic [1:0]          unit_enable;
  logic                mic_ok;
  logic                wr_en;
  logic                hit;
  logic                ks_last;
  logic                ci_last;
  logic                ks_trig;
  logic                ci_trig;
  logic                unit_on;
  logic                chain;
  logic [2:0]          next_events;
  logic [31:0]         next_rdata;

  // A write lands only at the access edge where pready is sampled high.
  assign wr_en   = psel & penable & pready & pwrite;
  assign ks_last = (state == ccm_pkg::CCM_KS) && (cnt == CW'(KS_CYCLES - 1));
  assign ci_last = (state == ccm_pkg::CCM_CI) && (cnt == CW'(CI_CYCLES - 1));
  assign unit_on = (unit_enable == ccm_pkg::UNIT_ON);
  assign ks_trig = wr_en && (paddr == ccm_pkg::OFF_KS_START) && pwdata[0] && unit_on;
  assign ci_trig = wr_en && (paddr == ccm_pkg::OFF_CI_START) && pwdata[0] && unit_on;
  assign chain   = ks_last && shortcut_en;

  always_comb begin
    case (paddr)
      ccm_pkg::OFF_KS_START, ccm_pkg::OFF_CI_START, ccm_pkg::OFF_KS_DONE, ccm_pkg::OFF_CI_DONE,
      ccm_pkg::OFF_ERR_EVENT, ccm_pkg::OFF_SHORTCUT, ccm_pkg::OFF_IRQ_SET, ccm_pkg::OFF_IRQ_CLR,
      ccm_pkg::OFF_MIC_RESULT, ccm_pkg::OFF_UNIT_EN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait slave: data and pready are prepared in the setup cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= !hit;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      ccm_pkg::OFF_KS_DONE:    next_rdata[0]   = events[ccm_pkg::BIT_KS_DONE];
      ccm_pkg::OFF_CI_DONE:    next_rdata[0]   = events[ccm_pkg::BIT_CI_DONE];
      ccm_pkg::OFF_ERR_EVENT:  next_rdata[0]   = events[ccm_pkg::BIT_ERROR];
      ccm_pkg::OFF_SHORTCUT:   next_rdata[0]   = shortcut_en;
      ccm_pkg::OFF_IRQ_SET:    next_rdata[2:0] = irq_en;
      ccm_pkg::OFF_IRQ_CLR:    next_rdata[2:0] = irq_en;
      ccm_pkg::OFF_MIC_RESULT: next_rdata[0]   = mic_ok;
      ccm_pkg::OFF_UNIT_EN:    next_rdata[1:0] = unit_enable;
      default:                 next_rdata      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      shortcut_en <= ccm_pkg::RST_SHORTCUT;
    end else if (wr_en && paddr == ccm_pkg::OFF_SHORTCUT) begin
      shortcut_en <= pwdata[ccm_pkg::BIT_SHORTCUT];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      unit_enable <= ccm_pkg::RST_UNIT_EN;
    end else if (wr_en && paddr == ccm_pkg::OFF_UNIT_EN) begin
      unit_enable <= pwdata[1:0];
    end
  end

  // set and clear of the enables, per event bit.
  // Set and clear live at different addresses, so they never meet in one cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en <= ccm_pkg::RST_IRQ_EN;
    end else if (wr_en && paddr == ccm_pkg::OFF_IRQ_SET) begin
      irq_en <= irq_en | pwdata[2:0];
    end else if (wr_en && paddr == ccm_pkg::OFF_IRQ_CLR) begin
      irq_en <= irq_en & ~pwdata[2:0];
    end
  end

  // engine: each task runs its fixed length and stops by itself.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ccm_pkg::CCM_IDLE;
      cnt   <= '0;
    end else if (!unit_on) begin
      state <= ccm_pkg::CCM_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        ccm_pkg::CCM_IDLE: begin
          cnt <= '0;
          if (ks_trig) begin
            state <= ccm_pkg::CCM_KS;
          end else if (ci_trig) begin
            state <= ccm_pkg::CCM_CI;
          end
        end
        ccm_pkg::CCM_KS: begin
          cnt <= ks_last ? '0 : cnt + 1'b1;
          if (ks_last) begin
            state <= chain ? ccm_pkg::CCM_CI : ccm_pkg::CCM_IDLE;
          end
        end
        ccm_pkg::CCM_CI: begin
          cnt <= ci_last ? '0 : cnt + 1'b1;
          if (ci_last) begin
            state <= ccm_pkg::CCM_IDLE;
          end
        end
        default: begin
          state <= ccm_pkg::CCM_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // Event flags: software writes store bit 0, a hardware event set wins over a clear.
  // A task trigger while the engine is busy raises the error event and is dropped.
  always_comb begin
    next_events = events;
    for (int i = 0; i < ccm_pkg::NUM_EVENTS; i++) begin
      if (wr_en && paddr == (ccm_pkg::OFF_KS_DONE + 12'(4 * i))) begin
        next_events[i] = pwdata[0];
      end
    end
    if (ks_last) begin
      next_events[ccm_pkg::BIT_KS_DONE] = 1'b1;
    end
    if (ci_last) begin
      next_events[ccm_pkg::BIT_CI_DONE] = 1'b1;
    end
    if ((ks_trig || ci_trig) && state != ccm_pkg::CCM_IDLE) begin
      next_events[ccm_pkg::BIT_ERROR] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      events <= ccm_pkg::RST_EVENTS;
    end else begin
      events <= next_events;
    end
  end

  // MIC result only updated by a finishing decryption.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mic_ok <= ccm_pkg::RST_MIC;
    end else if (ci_last && decrypt_mode) begin
      mic_ok <= mic_pass;
    end
  end

  // interrupt level, one cycle behind the flags.
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(events & irq_en);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      keystream_busy <= 1'b0;
      cipher_busy    <= 1'b0;
    end else begin
      keystream_busy <= (state == ccm_pkg::CCM_KS);
      cipher_busy    <= (state == ccm_pkg::CCM_CI);
    end
  end

  default clocking dflt @(posedge mclk); endclocking
  default disable iff (srst);

  shortcut_chain_a: assert property (chain |=> state == ccm_pkg::CCM_CI)
    else $error("shortcut did not start cipher");
  no_shortcut_a: assert property (ks_last && !shortcut_en |=> state == ccm_pkg::CCM_IDLE)
    else $error("cipher started without shortcut");
  set_enable_a: assert property (wr_en && paddr == ccm_pkg::OFF_IRQ_SET |=>
    (irq_en & $past(pwdata[2:0])) == $past(pwdata[2:0]))
    else $error("enable set write lost");
  clr_disable_a: assert property (wr_en && paddr == ccm_pkg::OFF_IRQ_CLR |=>
    (irq_en & $past(pwdata[2:0])) == 3'h0)
    else $error("enable clear write lost");
  enable_readback_a: assert property (psel && !penable && !pwrite && !pready &&
    (paddr == ccm_pkg::OFF_IRQ_SET || paddr == ccm_pkg::OFF_IRQ_CLR) |=> prdata[2:0] == $past(irq_en))
    else $error("enable readback wrong");
  unit_off_a: assert property (!unit_on |=> state == ccm_pkg::CCM_IDLE)
    else $error("engine ran while unit off");
  ks_done_a: assert property (ks_last |=> events[ccm_pkg::BIT_KS_DONE] ##1
    !keystream_busy)
    else $error("key-stream end not signalled");
  ci_done_a: assert property (ci_last |=> events[ccm_pkg::BIT_CI_DONE] ##1 !cipher_busy || ci_trig)
    else $error("cipher end not signalled");
  irq_level_a: assert property (##1 irq == $past(|(events & irq_en)))
    else $error("interrupt level mismatch");
  mic_readonly_a: assert property (!(ci_last && decrypt_mode) |=> $stable(mic_ok))
    else $error("MIC result changed without decryption");

  ready_after_setup_a: assert property (psel && !penable && !pready |=> pready)
    else $error("no answer after setup cycle");

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  unmapped_err_a: assert property (psel && !penable && !pready && !hit |=> pslverr)
    else $error("unmapped access not flagged");

  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");

  // read data zero outside answer
  // Zeroing the bus between answers keeps a stale value from looking like a read.
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  unmapped_write_a: assert property (wr_en && !hit |=>
    $stable(irq_en) && $stable(shortcut_en) && $stable(unit_enable))
    else $error("unmapped write changed a register");

  shortcut_store_a: assert property (wr_en && paddr == ccm_pkg::OFF_SHORTCUT |=>
    shortcut_en == $past(pwdata[ccm_pkg::BIT_SHORTCUT]))
    else $error("shortcut write lost");

  unit_store_a: assert property (wr_en && paddr == ccm_pkg::OFF_UNIT_EN |=>
    unit_enable == $past(pwdata[1:0]))
    else $error("unit enable write lost");

  off_start_ignored_a: assert property (wr_en && paddr == ccm_pkg::OFF_KS_START && !unit_on |=>
    state == ccm_pkg::CCM_IDLE)
    else $error("task started while unit off");

  ks_start_a: assert property (ks_trig && state == ccm_pkg::CCM_IDLE |=> state == ccm_pkg::CCM_KS)
    else $error("key-stream task not started");

  ci_start_a: assert property (ci_trig && state == ccm_pkg::CCM_IDLE |=> state == ccm_pkg::CCM_CI)
    else $error("cipher task not started");

  // busy trigger raises error
  // A trigger that lands on a busy engine is dropped, so software learns of it only here.
  busy_trigger_a: assert property ((ks_trig || ci_trig) && state != ccm_pkg::CCM_IDLE |=>
    events[ccm_pkg::BIT_ERROR])
    else $error("busy trigger did not raise error event");

  ks_busy_a: assert property (state == ccm_pkg::CCM_KS |=> keystream_busy)
    else $error("key-stream busy not shown");

  ci_busy_a: assert property (state == ccm_pkg::CCM_CI |=> cipher_busy)
    else $error("cipher busy not shown");

  irq_quiet_a: assert property (!(|(events & irq_en)) |=> !irq)
    else $error("interrupt high without enabled event");

  mic_update_a: assert property (ci_last && decrypt_mode |=> mic_ok == $past(mic_pass))
    else $error("MIC result not updated by decryption");

  chained_run_c: cover property (chain ##[1:40] ci_last);
  irq_raised_c: cover property ($rose(irq));
  error_event_c: cover property ($rose(events[ccm_pkg::BIT_ERROR]));
  // Main scenarios also include a finishing decryption and an unmapped access.
  decrypt_done_c: cover property (ci_last && decrypt_mode);
  unmapped_c: cover property (pslverr);

endmodule // ccm_ctrl

// file: tb/ccm_ctrl_tb_top.sv
// Self-checking testbench of the CCM control slice over APB.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ccm_ctrl_tb_top;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        decrypt_mode = 1'b0;
  logic        mic_pass = 1'b0;
  logic        pready, pslverr, keystream_busy, cipher_busy, irq;
  logic [31:0] prdata, rd;
  logic        err, mp, mic_exp;
  logic [2:0]  en_m, r3;
  int          fail_count = 0;
  int          checked = 0;

  always #5 mclk = ~mclk;

  ccm_ctrl #(.KS_CYCLES(2), .CI_CYCLES(5)) ccm_ctrl_inst (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .decrypt_mode(decrypt_mode), .mic_pass(mic_pass), .keystream_busy(keystream_busy),
    .cipher_busy(cipher_busy), .irq(irq));

  task automatic results;
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reads happen right after the edge, so pready is seen as it was sampled at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin fail_count++; $display("ERROR pready expected 1 seen %b", pready); results(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  // Busy shows a task one cycle after its start and the chain leaves no idle gap, so idle must hold for four cycles.
  task automatic wait_idle;
    int n, q;
    n = 0; q = 0;
    while (q < 4 && n < 80) begin
      @(posedge mclk); n++;
      if (keystream_busy === 1'b0 && cipher_busy === 1'b0) q++; else q = 0;
    end
    if (q < 4) begin fail_count++; $display("ERROR engine idle expected 1 seen 0"); results(); end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end

  initial begin
    logic [11:0] regs [6];
    regs = '{ccm_pkg::OFF_KS_DONE, ccm_pkg::OFF_CI_DONE, ccm_pkg::OFF_ERR_EVENT, ccm_pkg::OFF_SHORTCUT,
             ccm_pkg::OFF_IRQ_SET, ccm_pkg::OFF_UNIT_EN};
    void'($urandom(32'hf431));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    foreach (regs[i]) chk_rd(regs[i], 32'h0, "reset value");
    apb(1'b0, 12'h0ff, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    en_m = 3'h0;
    for (int i = 0; i < 8; i++) begin
      r3 = 3'($urandom);
      wr(ccm_pkg::OFF_IRQ_SET, {29'($urandom), r3});
      en_m = en_m | r3;
      chk_rd(ccm_pkg::OFF_IRQ_SET, {29'h0, en_m}, "enable set");
      r3 = 3'($urandom);
      wr(ccm_pkg::OFF_IRQ_CLR, {29'h0, r3});
      en_m = en_m & ~r3;
      chk_rd(ccm_pkg::OFF_IRQ_CLR, {29'h0, en_m}, "enable clear");
    end
    wr(ccm_pkg::OFF_IRQ_CLR, 32'h7);
    wr(ccm_pkg::OFF_KS_START, 32'h1);
    wait_idle();
    chk_rd(ccm_pkg::OFF_KS_DONE, 32'h0, "start while off");
    wr(ccm_pkg::OFF_UNIT_EN, {30'h0, ccm_pkg::UNIT_ON});
    chk_rd(ccm_pkg::OFF_UNIT_EN, 32'h2, "unit on");
    for (int s = 0; s < 2; s++) begin
      wr(ccm_pkg::OFF_SHORTCUT, 32'(s));
      chk_rd(ccm_pkg::OFF_SHORTCUT, 32'(s), "shortcut");
      wr(ccm_pkg::OFF_IRQ_SET, 32'h1);
      wr(ccm_pkg::OFF_KS_START, 32'h1);
      wait_idle();
      chk_rd(ccm_pkg::OFF_KS_DONE, 32'h1, "keystream done");
      `CHK("irq keystream", 1'b1, irq)
      chk_rd(ccm_pkg::OFF_CI_DONE, 32'(s), "chained cipher");
      wr(ccm_pkg::OFF_IRQ_CLR, 32'h1);
      repeat (2) @(posedge mclk);
      `CHK("irq masked", 1'b0, irq)
      wr(ccm_pkg::OFF_KS_DONE, 32'h0);
      wr(ccm_pkg::OFF_CI_DONE, 32'h0);
    end
    mic_exp = 1'b0;
    for (int i = 0; i < 6; i++) begin
      mp = 1'($urandom);
      mic_pass <= mp;
      decrypt_mode <= i[0];
      if (i[0]) mic_exp = mp;
      wr(ccm_pkg::OFF_CI_START, 32'h1);
      wait_idle();
      chk_rd(ccm_pkg::OFF_CI_DONE, 32'h1, "cipher done");
      chk_rd(ccm_pkg::OFF_MIC_RESULT, {31'h0, mic_exp}, "mic result");
      wr(ccm_pkg::OFF_MIC_RESULT, {31'h0, ~mic_exp});
      chk_rd(ccm_pkg::OFF_MIC_RESULT, {31'h0, mic_exp}, "mic read only");
      wr(ccm_pkg::OFF_CI_DONE, 32'h0);
    end
    wr(ccm_pkg::OFF_IRQ_SET, 32'h4);
    wr(ccm_pkg::OFF_CI_START, 32'h1);
    wr(ccm_pkg::OFF_CI_START, 32'h1);
    wait_idle();
    chk_rd(ccm_pkg::OFF_ERR_EVENT, 32'h1, "error event");
    `CHK("irq error", 1'b1, irq)
    wr(ccm_pkg::OFF_UNIT_EN, 32'h0);
    chk_rd(ccm_pkg::OFF_UNIT_EN, 32'h0, "unit off");
    results();
  end
endmodule // ccm_ctrl_tb_top
